/* File: pkg/fcrb_pkg.sv */
// Constants for the filter coefficient register bank
package fcrb_pkg;

	// Register index width; byte address is four times the index
	localparam int IDX_W = 7;
	localparam int IDX_LSB = 2;
	localparam int REG_COUNT = 11;
	localparam int SLOT_W = 4;
	localparam logic [SLOT_W-1:0] SLOT_NONE = 4'hf;
	localparam logic [7:0] RSVD_VALUE = 8'h00;

	// Register indices on page one
	localparam logic [IDX_W-1:0] IDX_RCH_NUM1_LO = 7'h32;
	localparam logic [IDX_W-1:0] IDX_RCH_DEN1_HI = 7'h33;
	localparam logic [IDX_W-1:0] IDX_RCH_DEN1_LO = 7'h34;
	localparam logic [IDX_W-1:0] IDX_SPATIAL_HI = 7'h35;
	localparam logic [IDX_W-1:0] IDX_SPATIAL_LO = 7'h36;
	localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 7'h37;
	localparam logic [IDX_W-1:0] IDX_RSVD_LAST = 7'h40;
	localparam logic [IDX_W-1:0] IDX_LHP_NUM0_HI = 7'h41;
	localparam logic [IDX_W-1:0] IDX_LHP_NUM0_LO = 7'h42;
	localparam logic [IDX_W-1:0] IDX_LHP_NUM1_HI = 7'h43;
	localparam logic [IDX_W-1:0] IDX_LHP_NUM1_LO = 7'h44;
	localparam logic [IDX_W-1:0] IDX_LHP_DEN1_HI = 7'h45;
	localparam logic [IDX_W-1:0] IDX_LHP_DEN1_LO = 7'h46;

	// Reset values
	localparam logic [7:0] RCH_NUM1_LO_RST = 8'h2d;
	localparam logic [7:0] RCH_DEN1_HI_RST = 8'h53;
	localparam logic [7:0] RCH_DEN1_LO_RST = 8'h7e;
	localparam logic [7:0] SPATIAL_HI_RST = 8'h7f;
	localparam logic [7:0] SPATIAL_LO_RST = 8'hff;
	localparam logic [7:0] LHP_NUM0_HI_RST = 8'h39;
	localparam logic [7:0] LHP_NUM0_LO_RST = 8'h55;
	localparam logic [7:0] LHP_NUM1_HI_RST = 8'hf3;
	localparam logic [7:0] LHP_NUM1_LO_RST = 8'h2d;
	localparam logic [7:0] LHP_DEN1_HI_RST = 8'h53;
	localparam logic [7:0] LHP_DEN1_LO_RST = 8'h7e;

	// Storage slot order: index and reset value per slot
	localparam logic [IDX_W-1:0] SLOT_IDX [REG_COUNT] = '{
		IDX_RCH_NUM1_LO, IDX_RCH_DEN1_HI, IDX_RCH_DEN1_LO, IDX_SPATIAL_HI,
		IDX_SPATIAL_LO, IDX_LHP_NUM0_HI, IDX_LHP_NUM0_LO, IDX_LHP_NUM1_HI,
		IDX_LHP_NUM1_LO, IDX_LHP_DEN1_HI, IDX_LHP_DEN1_LO};
	localparam logic [7:0] SLOT_RST [REG_COUNT] = '{
		RCH_NUM1_LO_RST, RCH_DEN1_HI_RST, RCH_DEN1_LO_RST, SPATIAL_HI_RST,
		SPATIAL_LO_RST, LHP_NUM0_HI_RST, LHP_NUM0_LO_RST, LHP_NUM1_HI_RST,
		LHP_NUM1_LO_RST, LHP_DEN1_HI_RST, LHP_DEN1_LO_RST};

	// Slot numbers used for the coefficient outputs
	localparam int SL_RCH_NUM1_LO = 0;
	localparam int SL_RCH_DEN1_HI = 1;
	localparam int SL_RCH_DEN1_LO = 2;
	localparam int SL_SPATIAL_HI = 3;
	localparam int SL_SPATIAL_LO = 4;
	localparam int SL_LHP_NUM0_HI = 5;
	localparam int SL_LHP_NUM0_LO = 6;
	localparam int SL_LHP_NUM1_HI = 7;
	localparam int SL_LHP_NUM1_LO = 8;
	localparam int SL_LHP_DEN1_HI = 9;
	localparam int SL_LHP_DEN1_LO = 10;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

endpackage : fcrb_pkg

/* File: pkg/fcrb_if.sv */
// Register access carrier between bus front end and byte storage
`timescale 1ns/10ps
`default_nettype none
interface fcrb_if;
	import fcrb_pkg::*;
	logic wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [7:0] wr_data;
	logic rd_en;
	logic [IDX_W-1:0] rd_idx;
	logic [7:0] rd_data;

	modport bus_side (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
	modport reg_side (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface : fcrb_if
`default_nettype wire

/* File: core/fcrb_ahb_slave.sv */
// AHB-Lite slave front end for the coefficient register bank
`timescale 1ns/10ps
`default_nettype none
module fcrb_ahb_slave
	import fcrb_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	fcrb_if.bus_side regs
);
	logic take;
	logic in_range;
	logic [IDX_W-1:0] addr_idx;
	logic wr_pend_reg;
	logic [IDX_W-1:0] wr_idx_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	// Address phase decode; addresses above the index field are unmapped
	assign take = hsel_i && htrans_i[1] && hready_i;
	assign in_range = (haddr_i[31:IDX_LSB+IDX_W] == '0);
	assign addr_idx = haddr_i[IDX_LSB+IDX_W-1:IDX_LSB];

	// Read index leaves in the address phase so data is ready for the data phase
	assign regs.rd_en = take && !hwrite_i && in_range;
	assign regs.rd_idx = addr_idx;
	assign regs.wr_en = wr_pend_reg;
	assign regs.wr_idx = wr_idx_reg;
	assign regs.wr_data = hwdata_i[7:0];
	// Unmapped reads answer zero; byte sits in the low lane
	assign hrdata_next = regs.rd_en ? {24'h00_0000, regs.rd_data} :
		(take ? 32'h0000_0000 : hrdata_reg);

	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = HRESP_OKAY;
	assign hrdata_o = hrdata_reg;

	// Write is held pending until its data phase
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= take && hwrite_i && in_range;
			wr_idx_reg <= take ? addr_idx : wr_idx_reg;
			hrdata_reg <= hrdata_next;
		end
	end

	default clocking cb_s @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	AST_HRDATA_HIGH_ZERO: assert property (
		take ##1 1'b1 |-> hrdata_o[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");

endmodule : fcrb_ahb_slave
`default_nettype wire

/* File: core/fcrb_top.sv */
// Filter coefficient register bank: byte storage, reserved block, coefficient outputs
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fcrb_top
	import fcrb_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [7:0] rch_deemph_num1_lo_o,
	output logic signed [15:0] rch_deemph_den1_o,
	output logic signed [15:0] spatial_atten_o,
	output logic signed [15:0] lch_highpass_num0_o,
	output logic signed [15:0] lch_highpass_num1_o,
	output logic signed [15:0] lch_highpass_den1_o
);

	// Map a register index to its storage slot, or none
	function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx);
		slot_of = SLOT_NONE;
		for (int s = 0; s < REG_COUNT; s++) begin
			if (idx == SLOT_IDX[s]) begin
				slot_of = SLOT_W'(s);
			end
		end
	endfunction : slot_of

	fcrb_if regs_if ();

	logic [SLOT_W-1:0] wr_slot;
	logic [SLOT_W-1:0] rd_slot;
	logic rd_rsvd;
	logic rd_hit;
	logic wr_hit;
	logic fwd_hit;
	logic [7:0] stored_byte;
	logic [7:0] byte_reg [REG_COUNT];
	logic [7:0] byte_next [REG_COUNT];

	// Bus front end; hsize is not decoded, only word transfers are expected
	fcrb_ahb_slave u_slave (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hready_i(hready_i),
		.hwdata_i(hwdata_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.regs(regs_if.bus_side)
	);

	// Slot decode for both directions
	assign wr_slot = slot_of(regs_if.wr_idx);
	assign rd_slot = slot_of(regs_if.rd_idx);
	assign wr_hit = regs_if.wr_en && (wr_slot != SLOT_NONE);
	assign rd_hit = rd_slot != SLOT_NONE;
	assign rd_rsvd = (regs_if.rd_idx >= IDX_RSVD_FIRST) && (regs_if.rd_idx <= IDX_RSVD_LAST);

	// Reserved block has no storage, so writes there fall away
	// Forwarding covers a read issued in the data phase of a write to the same byte
	assign fwd_hit = wr_hit && (wr_slot == rd_slot);
	assign stored_byte = rd_hit ? byte_reg[rd_slot] : RSVD_VALUE;
	assign regs_if.rd_data = rd_rsvd ? RSVD_VALUE :
		(fwd_hit ? regs_if.wr_data : stored_byte);

	// One byte register per slot; a write touches only its own slot
	for (genvar g = 0; g < REG_COUNT; g++) begin : g_byte
		assign byte_next[g] = (wr_hit && wr_slot == SLOT_W'(g)) ?
			regs_if.wr_data : byte_reg[g];
		always_ff @(posedge clock_i) begin
			if (srst_i) begin
				byte_reg[g] <= SLOT_RST[g];
			end else begin
				byte_reg[g] <= byte_next[g];
			end
		end
	end

	// Coefficients to the filters: upper byte over lower byte, signed; the right numerator one low byte goes out alone, unsigned
	assign rch_deemph_num1_lo_o = byte_reg[SL_RCH_NUM1_LO];
	assign rch_deemph_den1_o = $signed({byte_reg[SL_RCH_DEN1_HI],
		byte_reg[SL_RCH_DEN1_LO]});
	assign spatial_atten_o = $signed({byte_reg[SL_SPATIAL_HI],
		byte_reg[SL_SPATIAL_LO]});
	assign lch_highpass_num0_o = $signed({byte_reg[SL_LHP_NUM0_HI],
		byte_reg[SL_LHP_NUM0_LO]});
	assign lch_highpass_num1_o = $signed({byte_reg[SL_LHP_NUM1_HI],
		byte_reg[SL_LHP_NUM1_LO]});
	assign lch_highpass_den1_o = $signed({byte_reg[SL_LHP_DEN1_HI],
		byte_reg[SL_LHP_DEN1_LO]});

	// Checks on the stored coefficients and their readback
	default clocking cb_t @(posedge clock_i);
	endclocking
	default disable iff (srst_i);

	// Upper byte write changes only the upper half
	AST_HI_WRITE_KEEPS_LO: assert property (
		regs_if.wr_en && regs_if.wr_idx == IDX_RCH_DEN1_HI
		|=> rch_deemph_den1_o[15:8] == $past(regs_if.wr_data)
			&& rch_deemph_den1_o[7:0] == $past(rch_deemph_den1_o[7:0]))
		else $error("upper byte write did not land in upper half");

	// Sign follows bit seven of the upper byte
	AST_SIGNED_COEF: assert property (
		regs_if.wr_en && regs_if.wr_idx == IDX_SPATIAL_HI
		|=> (spatial_atten_o < 16'sh0000) == $past(regs_if.wr_data[7]))
		else $error("coefficient sign does not follow upper byte");

	// Reserved block reads zero in the following data phase
	AST_RSVD_READS_ZERO: assert property (
		regs_if.rd_en && regs_if.rd_idx >= IDX_RSVD_FIRST
			&& regs_if.rd_idx <= IDX_RSVD_LAST
		|=> hrdata_o == 32'h0000_0000)
		else $error("reserved location read non-zero");

	// Reset values after release
	AST_SPATIAL_RESET: assert property (
		$fell(srst_i) |-> spatial_atten_o == $signed({SPATIAL_HI_RST, SPATIAL_LO_RST}))
		else $error("spatial attenuation reset value wrong");

	AST_RCH_DEN1_RESET: assert property (
		$fell(srst_i) |-> rch_deemph_den1_o == $signed({RCH_DEN1_HI_RST, RCH_DEN1_LO_RST}))
		else $error("right denominator one reset value wrong");

	AST_RCH_NUM1_LO_RESET: assert property (
		$fell(srst_i) |-> rch_deemph_num1_lo_o == RCH_NUM1_LO_RST)
		else $error("right numerator one low reset value wrong");

	AST_LHP_NUM0_RESET: assert property (
		$fell(srst_i) |-> lch_highpass_num0_o == $signed({LHP_NUM0_HI_RST, LHP_NUM0_LO_RST}))
		else $error("left numerator zero reset value wrong");

	AST_LHP_NUM1_RESET: assert property (
		$fell(srst_i) |-> lch_highpass_num1_o == $signed({LHP_NUM1_HI_RST, LHP_NUM1_LO_RST}))
		else $error("left numerator one reset value wrong");

	AST_LHP_DEN1_RESET: assert property (
		$fell(srst_i) |-> lch_highpass_den1_o == $signed({LHP_DEN1_HI_RST, LHP_DEN1_LO_RST}))
		else $error("left denominator one reset value wrong");

	// Lower byte of left denominator one lives at its own index
	AST_LHP_DEN1_LO_WRITE: assert property (
		regs_if.wr_en && regs_if.wr_idx == IDX_LHP_DEN1_LO
		|=> lch_highpass_den1_o[7:0] == $past(regs_if.wr_data)
			&& lch_highpass_den1_o[15:8] == $past(lch_highpass_den1_o[15:8]))
		else $error("left denominator one low write misplaced");

	// Right numerator one low byte: write lands, read returns it
	AST_RCH_NUM1_LO_WRITE: assert property (
		regs_if.wr_en && regs_if.wr_idx == IDX_RCH_NUM1_LO
		|=> rch_deemph_num1_lo_o == $past(regs_if.wr_data))
		else $error("right numerator one low write lost");

	AST_RCH_NUM1_LO_READ: assert property (
		regs_if.rd_en && regs_if.rd_idx == IDX_RCH_NUM1_LO && !regs_if.wr_en
		|=> hrdata_o[7:0] == $past(rch_deemph_num1_lo_o))
		else $error("right numerator one low read wrong");

	// Back to back write then read of the same byte sees the new value
	AST_WRITE_READ_FORWARD: assert property (
		wr_hit && regs_if.rd_en && regs_if.rd_idx == regs_if.wr_idx
		|=> hrdata_o[7:0] == $past(regs_if.wr_data))
		else $error("read after write returned stale byte");

	// Without a write, coefficients stay put
	AST_COEF_STABLE: assert property (
		!regs_if.wr_en |=> $stable(spatial_atten_o) && $stable(lch_highpass_num1_o))
		else $error("coefficient changed without a write");

	// Main scenarios
	COV_WRITE_THEN_READ: cover property (
		wr_hit ##1 regs_if.rd_en && regs_if.rd_idx == $past(regs_if.wr_idx));
	COV_RSVD_READ: cover property (
		regs_if.rd_en && regs_if.rd_idx == IDX_RSVD_LAST);
	COV_NEG_COEF: cover property (
		lch_highpass_num0_o < 16'sh0000);
	COV_FORWARD: cover property (
		fwd_hit && regs_if.rd_en);

endmodule : fcrb_top
`default_nettype wire

/* File: dv/filter_coefficient_register_bank_bench.sv */
// Self-checking bench for the filter coefficient register bank
`timescale 1ns/10ps
`default_nettype none
module filter_coefficient_register_bank_bench
	import fcrb_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	wire logic [31:0] hrdata;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [7:0] num1_lo;
	wire logic signed [15:0] rden1, spat, lnum0, lnum1, lden1;
	integer fail_count = 0;
	integer compares = 0;
	integer seed = 32'h364500b2;
	logic [31:0] exp_q[$];
	logic [7:0] exp_b [REG_COUNT];
	logic rd_dphase = 1'b0;
	// Reset values in storage slot order, kept apart from the design's own table
	logic [7:0] rst_tab [REG_COUNT] = '{8'h2d, 8'h53, 8'h7e, 8'h7f, 8'hff, 8'h39, 8'h55, 8'hf3,
		8'h2d, 8'h53, 8'h7e};

	// Clock at 200 MHz
	initial begin
		forever #2.5 clk = ~clk;
	end

	// Single slave, so its ready is the bus ready
	fcrb_top DUT (.clock_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout),
		.hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.rch_deemph_num1_lo_o(num1_lo), .rch_deemph_den1_o(rden1), .spatial_atten_o(spat),
		.lch_highpass_num0_o(lnum0), .lch_highpass_num1_o(lnum1), .lch_highpass_den1_o(lden1));

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task close_out;
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// Bounded wait for hready; a stuck bus ends the run
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, hreadyout, 1'b1);
			close_out();
		end
	endtask : wait_ready

	// One single word transfer: address phase, then data phase
	task xfer(input logic wr, input logic [31:0] addr, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= addr;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		// Random upper lanes reach the bus; only the low byte may be stored
		hwdata <= {24'($random(seed)), d};
		wait_ready();
		check({31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask : xfer

	task wr_reg(input logic [6:0] idx, input logic [7:0] d);
		for (int i = 0; i < REG_COUNT; i++)
			if (SLOT_IDX[i] == idx)
				exp_b[i] = d;
		xfer(1'b1, {23'h0, idx, 2'b00}, d);
	endtask : wr_reg

	// Expected read data is noted before the transfer starts
	task rd_addr(input logic [31:0] addr, input logic [7:0] exp);
		exp_q.push_back({24'h0, exp});
		xfer(1'b0, addr, 8'h00);
	endtask : rd_addr

	task check_coefs;
		@(negedge clk);
		check({24'h0, num1_lo}, {24'h0, exp_b[SL_RCH_NUM1_LO]});
		check({16'h0, rden1}, {16'h0, exp_b[SL_RCH_DEN1_HI], exp_b[SL_RCH_DEN1_LO]});
		check({16'h0, spat}, {16'h0, exp_b[SL_SPATIAL_HI], exp_b[SL_SPATIAL_LO]});
		check({16'h0, lnum0}, {16'h0, exp_b[SL_LHP_NUM0_HI], exp_b[SL_LHP_NUM0_LO]});
		check({16'h0, lnum1}, {16'h0, exp_b[SL_LHP_NUM1_HI], exp_b[SL_LHP_NUM1_LO]});
		check({16'h0, lden1}, {16'h0, exp_b[SL_LHP_DEN1_HI], exp_b[SL_LHP_DEN1_LO]});
	endtask : check_coefs

	task read_all;
		for (int i = 0; i < REG_COUNT; i++)
			rd_addr({23'h0, SLOT_IDX[i], 2'b00}, exp_b[i]);
	endtask : read_all

	// Watcher: read data is taken at the edge that closes its data phase
	always @(posedge clk) begin
		if (rd_dphase && exp_q.size() > 0)
			check(hrdata, exp_q.pop_front());
		rd_dphase <= hsel & htrans[1] & hreadyout & ~hwrite;
	end

	// Page one is taken as selected before any access
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		exp_b = rst_tab;
		check_coefs();
		read_all();
		$display("test reset_values done");
		// Reserved block is only read, never written
		for (int i = 55; i <= 64; i++) begin
			rd_addr(32'(i * 4), RSVD_VALUE);
		end
		// Writes above the page alias real indices and must not land
		for (int i = 0; i < REG_COUNT; i++) begin
			xfer(1'b1, {23'h1, SLOT_IDX[i], 2'b00}, 8'ha5);
		end
		rd_addr(32'h0000_0200 | 32'h0000_00d4, 8'h00);
		rd_addr(32'h0000_011c, 8'h00);
		check_coefs();
		$display("test reserved_block done");
		// Random byte writes, one at a time, partner byte must stay put
		repeat (3) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				wr_reg(SLOT_IDX[i], 8'($random(seed)));
				check_coefs();
			end
		end
		read_all();
		$display("test byte_writes done");
		// Extremes of the signed range
		wr_reg(IDX_SPATIAL_HI, 8'h80);
		wr_reg(IDX_SPATIAL_LO, 8'h00);
		check_coefs();
		check({31'h0, spat < 16'sd0}, 32'h1);
		wr_reg(IDX_LHP_DEN1_HI, 8'h7f);
		wr_reg(IDX_LHP_DEN1_LO, 8'hff);
		check_coefs();
		check({31'h0, lden1 == 16'sd32767}, 32'h1);
		$display("test signed_range done");
		// Reset in mid-run restores every byte
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		exp_b = rst_tab;
		check_coefs();
		read_all();
		repeat (2) @(posedge clk);
		check(32'(exp_q.size()), 32'h0000_0000);
		$display("test second_reset done");
		close_out();
	end
endmodule : filter_coefficient_register_bank_bench
`default_nettype wire
